/* File: design/scbb_top.sv */
// Scan cascade trigger, scan sequencing and beam blanking substitution
// Operation
// (R1) Cascade 0 scans continuously; cascade 1 makes every scan wait for a trigger.
// (R2) Role 0 follows an incoming trigger; role 1 leads and drives the trigger line.
// (R3) Leader emits one trigger pulse per programmed cycle, of programmed microsecond width.
// (R4) After a trigger, wait the programmed microsecond delay before starting the scan; code raises a programmed delay below 500 us to 500 us.
// (R5) Host gives each follower a distinct delay so scans are offset.
// (R6) Up to four beam areas are blanked and their states substituted.
// (R7) Code 0 unused, 1 forces 0, 2 forces 1, 3 copies lower, 4 copies higher.
// (R8) Each area is bounded by first and last beam numbers, 1 to 1774.
// (R9) Auto blanking finds and suppresses up to four interfering areas during teach.
// (R10) Auto enable 0 keeps manual areas; 1 lets teach set the boundaries.
// (R11) Auto area limit 0 to 4 caps how many areas a teach creates.
// (R12) Operator enables auto blanking only during commissioning.
// (R13) Host starts a new teach after any blanking change.
// (R14) Teach requests come from the panel or from a configuration command.
// (R15) Follower counts from the trigger rising edge and ignores triggers until scan ends.
// (R16) Substitution is applied to every completed scan before beams are passed on.
`timescale 1ns/10ps
module scbb_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Parameter record port
  input wire logic rec_wr,
  input wire logic rec_rd,
  input wire logic [7:0] rec_index,
  input wire logic [207:0] rec_wdata,
  output logic [207:0] rec_rdata,
  output logic rec_ack,
  // Trigger line
  input wire logic trig_in,
  output logic trig_out,
  output logic trig_oe,
  // Teach requests
  input wire logic teach_panel,
  input wire logic teach_cmd,
  output logic teach_busy,
  // Raw beam stream from the front end
  input wire logic beam_valid,
  input wire logic beam_state,
  input wire logic beam_end,
  output logic scan_start,
  // Substituted beam stream
  output logic out_valid,
  output logic out_state,
  output logic out_last
);
  scbb_pkg::scbb_trig_type trig_reg;
  scbb_pkg::scbb_blank_type blank_reg;
  scbb_pkg::scbb_state_type state_reg, state_next;
  logic [5:0] us_cnt_reg;
  logic [9:0] ms_cnt_reg;
  logic [15:0] cyc_cnt_reg, pw_cnt_reg, dly_cnt_reg;
  logic [10:0] idx_reg, len_reg, out_num_reg;
  logic [2:0] n_made_reg;
  logic trig_q_reg, in_run_reg, teach_req_reg, teach_scan_reg;
  logic raw_mem [1:scbb_pkg::NBEAMS];
  logic [207:0] rdata_reg;
  logic ack_reg, trig_out_reg, trig_oe_reg, scan_start_reg, teach_busy_reg;
  logic out_valid_reg, out_state_reg, out_last_reg;

  function automatic logic area_hit(input scbb_pkg::scbb_area_type a, input logic [10:0] n);
    area_hit = (a.code != scbb_pkg::SUB_NONE) && (16'(n) >= a.first) && (16'(n) <= a.last);
  endfunction
  function automatic logic raw_at(input logic [15:0] n);
    raw_at = (n >= 16'(scbb_pkg::BEAM_FIRST) && n <= 16'(scbb_pkg::BEAM_LAST)) ? raw_mem[11'(n)] : 1'b0;
  endfunction
  function automatic logic beam_out(input logic [10:0] n);
    logic v;
    logic done;
    v = raw_mem[n];
    done = 1'b0;
    for (int k = 0; k < scbb_pkg::NAREAS; k++) begin
      if (!done && area_hit(blank_reg.area[k], n)) begin // R6 R8
        done = 1'b1;
        case (blank_reg.area[k].code) // R7
          scbb_pkg::SUB_ZERO: v = 1'b0;
          scbb_pkg::SUB_ONE: v = 1'b1;
          scbb_pkg::SUB_LOWER: v = raw_at(blank_reg.area[k].first - 16'h0001);
          scbb_pkg::SUB_HIGHER: v = raw_at(blank_reg.area[k].last + 16'h0001);
          default: v = raw_mem[n];
        endcase
      end
    end
    beam_out = v;
  endfunction
  // Time base
  wire us_tick = (us_cnt_reg == scbb_pkg::CYC_PER_US - 6'h01);
  wire ms_tick = us_tick && (ms_cnt_reg == scbb_pkg::US_PER_MS - 10'h001);
  wire casc_on = (trig_reg.cascade != scbb_pkg::CASC_OFF);
  wire leader = (trig_reg.role == scbb_pkg::ROLE_LEADER);
  wire [15:0] cycle_eff = (trig_reg.cycle_ms == 16'h0000) ? scbb_pkg::CYCLE_DEF_MS : trig_reg.cycle_ms;
  wire [15:0] delay_eff = (trig_reg.delay_us < scbb_pkg::DELAY_MIN_US) ? scbb_pkg::DELAY_MIN_US
                                                                         : trig_reg.delay_us;
  wire fire = leader && ms_tick && (cyc_cnt_reg >= cycle_eff - 16'h0001); // R3
  wire trig_edge = trig_in && !trig_q_reg; // R15
  wire ref_evt = leader ? fire : trig_edge; // R2
  // First tick in DELAY is partial, so one extra tick keeps the wait at least the programmed delay
  wire dly_done = us_tick && (dly_cnt_reg >= delay_eff); // R4
  wire teach_take = (state_next == scbb_pkg::ST_SCAN) && (state_reg != scbb_pkg::ST_SCAN);
  wire auto_on = teach_scan_reg && (blank_reg.auto_en == scbb_pkg::AUTO_ON); // R10
  wire out_end = (out_num_reg == len_reg);
  wire idx_ok = (idx_reg <= scbb_pkg::BEAM_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scbb_pkg::ST_IDLE: state_next = casc_on ? scbb_pkg::ST_WAIT : scbb_pkg::ST_SCAN; // R1
      scbb_pkg::ST_WAIT: if (!casc_on) state_next = scbb_pkg::ST_SCAN;
                         else if (ref_evt) state_next = scbb_pkg::ST_DELAY; // R1 R15
      scbb_pkg::ST_DELAY: if (dly_done) state_next = scbb_pkg::ST_SCAN; // R4
      scbb_pkg::ST_SCAN: if (beam_valid && beam_end) state_next = scbb_pkg::ST_OUT;
      scbb_pkg::ST_OUT: if (out_end) state_next = scbb_pkg::ST_IDLE; // R16
      default: state_next = scbb_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= scbb_pkg::ST_IDLE;
      us_cnt_reg <= 6'h00;
      ms_cnt_reg <= 10'h000;
      cyc_cnt_reg <= 16'h0000;
      pw_cnt_reg <= 16'h0000;
      dly_cnt_reg <= 16'h0000;
      trig_q_reg <= 1'b0;
      trig_out_reg <= 1'b0;
      trig_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      us_cnt_reg <= us_tick ? 6'h00 : us_cnt_reg + 6'h01;
      if (us_tick) ms_cnt_reg <= ms_tick ? 10'h000 : ms_cnt_reg + 10'h001;
      if (fire) cyc_cnt_reg <= 16'h0000;
      else if (ms_tick) cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
      trig_q_reg <= trig_in;
      trig_oe_reg <= leader && casc_on; // R2
      if (fire && casc_on) begin // R3
        trig_out_reg <= 1'b1;
        pw_cnt_reg <= 16'h0000;
      end else if (trig_out_reg && us_tick) begin
        pw_cnt_reg <= pw_cnt_reg + 16'h0001;
        if (pw_cnt_reg >= trig_reg.pulse_us - 16'h0001) trig_out_reg <= 1'b0;
      end
      if (state_reg != scbb_pkg::ST_DELAY) dly_cnt_reg <= 16'h0000;
      else if (us_tick) dly_cnt_reg <= dly_cnt_reg + 16'h0001;
    end
  end
  // Record port; teach may rewrite the blanking areas
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_reg <= scbb_pkg::TRIG_RESET;
      blank_reg <= scbb_pkg::BLANK_RESET;
      rdata_reg <= 208'h0;
      ack_reg <= 1'b0;
      teach_req_reg <= 1'b0;
      teach_scan_reg <= 1'b0;
      teach_busy_reg <= 1'b0;
      in_run_reg <= 1'b0;
      n_made_reg <= 3'h0;
    end else begin
      ack_reg <= rec_wr || rec_rd;
      if (rec_rd) begin
        case (rec_index)
          scbb_pkg::IDX_TRIGGER: rdata_reg <= 208'(trig_reg);
          scbb_pkg::IDX_BLANKING: rdata_reg <= blank_reg;
          default: rdata_reg <= 208'h0;
        endcase
      end
      if (rec_wr && rec_index == scbb_pkg::IDX_TRIGGER) trig_reg <= rec_wdata[63:0];
      if (rec_wr && rec_index == scbb_pkg::IDX_BLANKING) blank_reg <= rec_wdata;
      teach_req_reg <= (teach_req_reg && !teach_take) || teach_panel || teach_cmd; // R14
      teach_busy_reg <= teach_scan_reg;
      if (teach_take) begin
        teach_scan_reg <= teach_req_reg;
        in_run_reg <= 1'b0;
        n_made_reg <= 3'h0;
        if (teach_req_reg && blank_reg.auto_en == scbb_pkg::AUTO_ON) begin // R9
          for (int k = 0; k < scbb_pkg::NAREAS; k++) blank_reg.area[k] <= scbb_pkg::AREA_RESET;
        end
      end else if (state_reg == scbb_pkg::ST_OUT && out_end) begin
        teach_scan_reg <= 1'b0;
      end
      if (auto_on && state_reg == scbb_pkg::ST_SCAN && beam_valid && idx_ok) begin // R9
        if (beam_state) begin
          in_run_reg <= 1'b0;
        end else if (in_run_reg) begin
          blank_reg.area[2'(n_made_reg - 3'h1)].last <= 16'(idx_reg);
        end else if (8'(n_made_reg) < blank_reg.auto_limit) begin // R11
          blank_reg.area[2'(n_made_reg)] <= '{code: scbb_pkg::AUTO_CODE, first: 16'(idx_reg),
                                              last: 16'(idx_reg)};
          n_made_reg <= n_made_reg + 3'h1;
          in_run_reg <= 1'b1;
        end
      end
    end
  end

  // Capture the raw scan, then stream it out substituted
  always_ff @(posedge clk) begin
    if (state_reg == scbb_pkg::ST_SCAN && beam_valid && idx_ok) raw_mem[idx_reg] <= beam_state;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_reg <= scbb_pkg::BEAM_FIRST;
      len_reg <= scbb_pkg::BEAM_FIRST;
      out_num_reg <= scbb_pkg::BEAM_FIRST;
      scan_start_reg <= 1'b0;
      out_valid_reg <= 1'b0;
      out_state_reg <= 1'b0;
      out_last_reg <= 1'b0;
    end else begin
      scan_start_reg <= teach_take;
      if (state_reg != scbb_pkg::ST_SCAN) idx_reg <= scbb_pkg::BEAM_FIRST;
      else if (beam_valid && idx_ok) idx_reg <= idx_reg + 11'h001;
      if (state_reg == scbb_pkg::ST_SCAN && beam_valid && beam_end) begin
        len_reg <= idx_ok ? idx_reg : scbb_pkg::BEAM_LAST;
      end
      out_valid_reg <= (state_reg == scbb_pkg::ST_OUT);
      out_last_reg <= (state_reg == scbb_pkg::ST_OUT) && out_end;
      if (state_reg == scbb_pkg::ST_OUT) begin
        out_state_reg <= beam_out(out_num_reg); // R16
        out_num_reg <= out_end ? scbb_pkg::BEAM_FIRST : out_num_reg + 11'h001;
      end
    end
  end

  assign rec_rdata = rdata_reg;
  assign rec_ack = ack_reg;
  assign trig_out = trig_out_reg;
  assign trig_oe = trig_oe_reg;
  assign teach_busy = teach_busy_reg;
  assign scan_start = scan_start_reg;
  assign out_valid = out_valid_reg;
  assign out_state = out_state_reg;
  assign out_last = out_last_reg;

  // Checks
  logic [21:0] hi_cyc_reg;
  logic [10:0] prev_num_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_cyc_reg <= 22'h0;
      prev_num_reg <= 11'h0;
    end else begin
      hi_cyc_reg <= trig_out_reg ? hi_cyc_reg + 22'h1 : 22'h0;
      prev_num_reg <= out_num_reg;
    end
  end
  property p_continuous;
    @(posedge clk) disable iff (!rst_b) (state_reg == scbb_pkg::ST_IDLE && !casc_on) |=> scan_start_reg;
  endproperty
  a_continuous: assert property (p_continuous) else $error("continuous mode did not start a scan"); // R1
  property p_wait;
    @(posedge clk) disable iff (!rst_b) (state_reg == scbb_pkg::ST_WAIT && casc_on && !ref_evt) |=> !scan_start_reg;
  endproperty
  a_wait: assert property (p_wait) else $error("scan started without trigger"); // R1
  property p_follower_quiet;
    @(posedge clk) disable iff (!rst_b) !leader |=> !trig_oe_reg && !$rose(trig_out_reg);
  endproperty
  a_follower_quiet: assert property (p_follower_quiet) else $error("follower drove trigger"); // R2
  property p_pulse_width;
    @(posedge clk) disable iff (!rst_b) $fell(trig_out_reg) && $stable(trig_reg.pulse_us) |->
      $past(hi_cyc_reg) + 22'h1 <= 22'(trig_reg.pulse_us) * 22'(scbb_pkg::CYC_PER_US) &&
      $past(hi_cyc_reg) + 22'h1 + 22'(scbb_pkg::CYC_PER_US) >= 22'(trig_reg.pulse_us) * 22'(scbb_pkg::CYC_PER_US);
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("trigger pulse width wrong"); // R3
  property p_delay_min;
    @(posedge clk) disable iff (!rst_b) (state_reg == scbb_pkg::ST_DELAY) && (state_next == scbb_pkg::ST_SCAN) |->
      dly_cnt_reg >= delay_eff;
  endproperty
  a_delay_min: assert property (p_delay_min) else $error("scan started before delay expired"); // R4
  property p_ignore;
    @(posedge clk) disable iff (!rst_b) (state_reg == scbb_pkg::ST_SCAN && !(beam_valid && beam_end)) |=>
      state_reg == scbb_pkg::ST_SCAN;
  endproperty
  a_ignore: assert property (p_ignore) else $error("scan left early"); // R15
  property p_force0;
    @(posedge clk) disable iff (!rst_b) out_valid_reg && area_hit(blank_reg.area[0], prev_num_reg) &&
      blank_reg.area[0].code == scbb_pkg::SUB_ZERO && $stable(blank_reg) |-> !out_state_reg;
  endproperty
  a_force0: assert property (p_force0) else $error("blanked beam not forced to 0"); // R7
  property p_force1;
    @(posedge clk) disable iff (!rst_b) out_valid_reg && area_hit(blank_reg.area[0], prev_num_reg) &&
      blank_reg.area[0].code == scbb_pkg::SUB_ONE && $stable(blank_reg) |-> out_state_reg;
  endproperty
  a_force1: assert property (p_force1) else $error("blanked beam not forced to 1"); // R7
  property p_auto_limit;
    @(posedge clk) disable iff (!rst_b) auto_on && $stable(blank_reg.auto_limit) |-> 8'(n_made_reg) <= blank_reg.auto_limit;
  endproperty
  a_auto_limit: assert property (p_auto_limit) else $error("too many auto areas"); // R11
  property p_out_after_scan;
    @(posedge clk) disable iff (!rst_b) $rose(out_valid_reg) |-> $past(state_reg, 2) == scbb_pkg::ST_SCAN;
  endproperty
  a_out_after_scan: assert property (p_out_after_scan) else $error("output before scan completed"); // R16
  c_leader_pulse: cover property (@(posedge clk) disable iff (!rst_b) $fell(trig_out_reg));
  c_follower_scan: cover property (@(posedge clk) disable iff (!rst_b) !leader && casc_on && $rose(scan_start_reg));
  c_auto_area: cover property (@(posedge clk) disable iff (!rst_b) auto_on && n_made_reg == 3'h1);
endmodule // scbb_top

/* File: design/scbb_pkg.sv */
// Package for the scan cascade and beam blanking block
package scbb_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned US_PER_S = 1000000;
  localparam logic [5:0] CYC_PER_US = 6'(CLK_HZ / US_PER_S);
  localparam logic [9:0] US_PER_MS = 10'h3e8;
  localparam logic [7:0] IDX_TRIGGER = 8'h49;
  localparam logic [7:0] IDX_BLANKING = 8'h4c;
  localparam int unsigned NBEAMS = 1774;
  localparam int unsigned NAREAS = 4;
  localparam logic [10:0] BEAM_FIRST = 11'h001;
  localparam logic [10:0] BEAM_LAST = 11'h6ee;
  localparam logic [15:0] DELAY_MIN_US = 16'h01f4;
  localparam logic [15:0] PULSE_DEF_US = 16'h0064;
  localparam logic [15:0] CYCLE_DEF_MS = 16'h0001;
  localparam logic [7:0] CASC_OFF = 8'h00;
  localparam logic [7:0] ROLE_LEADER = 8'h01;
  localparam logic [15:0] SUB_NONE = 16'h0000;
  localparam logic [15:0] SUB_ZERO = 16'h0001;
  localparam logic [15:0] SUB_ONE = 16'h0002;
  localparam logic [15:0] SUB_LOWER = 16'h0003;
  localparam logic [15:0] SUB_HIGHER = 16'h0004;
  localparam logic [15:0] AUTO_CODE = SUB_ONE;
  localparam logic [15:0] BEAM_DEF = 16'h0001;
  localparam logic [7:0] AUTO_ON = 8'h01;

  typedef struct packed {
    logic [7:0] cascade;
    logic [7:0] role;
    logic [15:0] delay_us;
    logic [15:0] pulse_us;
    logic [15:0] cycle_ms;
  } scbb_trig_type;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] first;
    logic [15:0] last;
  } scbb_area_type;

  typedef struct packed {
    logic [7:0] auto_limit;
    logic [7:0] auto_en;
    scbb_area_type [0:NAREAS-1] area;
  } scbb_blank_type;

  localparam scbb_trig_type TRIG_RESET = '{cascade: CASC_OFF, role: 8'h00, delay_us: DELAY_MIN_US,
                                           pulse_us: PULSE_DEF_US, cycle_ms: CYCLE_DEF_MS};
  localparam scbb_area_type AREA_RESET = '{code: SUB_NONE, first: BEAM_DEF, last: BEAM_DEF};
  localparam scbb_blank_type BLANK_RESET = '{auto_limit: 8'h00, auto_en: 8'h00,
                                             area: '{AREA_RESET, AREA_RESET, AREA_RESET, AREA_RESET}};

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_SCAN, ST_OUT} scbb_state_type;
endpackage

/* File: verif/scbb_partner.sv */
// Far-side model: scan front end and a neighbouring leader curtain
`timescale 1ns/10ps
module scbb_partner #(
  parameter int unsigned PULSE_CYC = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Front end
  input wire logic scan_start,
  input wire logic [15:0] pattern,
  output logic beam_valid,
  output logic beam_state,
  output logic beam_end,
  // Neighbour trigger
  input wire logic fire,
  output logic trig_drv
);
  logic [4:0] idx;
  logic [15:0] tcnt;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx <= 5'h00;
      beam_valid <= 1'b0;
      beam_state <= 1'b0;
      beam_end <= 1'b0;
      tcnt <= 16'h0000;
      trig_drv <= 1'b0;
    end else begin
      beam_valid <= (idx != 5'h00);
      beam_end <= (idx == 5'h10);
      // Outside a scan the state line toggles so no stale value looks valid
      beam_state <= (idx != 5'h00) ? pattern[idx - 5'h01] : ~beam_state;
      idx <= scan_start ? 5'h01 : ((idx == 5'h00) || (idx == 5'h10)) ? 5'h00 : idx + 5'h01;
      tcnt <= fire ? 16'(PULSE_CYC) : tcnt - 16'(tcnt != 16'h0000);
      trig_drv <= (tcnt != 16'h0000);
    end
  end
endmodule // scbb_partner

/* File: verif/scbb_top_tb.sv */
// Self-checking bench for the scan cascade and beam blanking block
`timescale 1ns/10ps
module scbb_top_tb;
  localparam logic [15:0] PAT = 16'hb5a3;
  localparam logic [207:0] BLK = {16'h0000, 48'h0001_0002_0003, 48'h0002_0005_0006, 48'h0003_0008_0009,
                                  48'h0004_000b_000c};
  localparam logic [207:0] TAUGHT = {16'h0100, 48'h0002_0007_0008, {3{48'h0000_0001_0001}}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rec_wr = 1'b0;
  logic rec_rd = 1'b0;
  logic [7:0] rec_index = 8'h00;
  logic [207:0] rec_wdata = '0;
  logic [207:0] rec_rdata;
  logic rec_ack, trig_out, trig_oe, trig_drv, trig_line, teach_busy, scan_start;
  logic teach_panel = 1'b0;
  logic teach_cmd = 1'b0;
  logic fire = 1'b0;
  logic [15:0] pattern = PAT;
  logic beam_valid, beam_state, beam_end, out_valid, out_state, out_last, s;
  logic [15:0] v, e;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n, m;

  always #12.5 clk = ~clk;
  // Shared trigger line with pull-down
  assign trig_line = (trig_oe & trig_out) | trig_drv;

  scbb_top i_scbb_top (.clk(clk), .rst_b(rst_b), .rec_wr(rec_wr), .rec_rd(rec_rd), .rec_index(rec_index),
    .rec_wdata(rec_wdata), .rec_rdata(rec_rdata), .rec_ack(rec_ack), .trig_in(trig_line), .trig_out(trig_out),
    .trig_oe(trig_oe), .teach_panel(teach_panel), .teach_cmd(teach_cmd), .teach_busy(teach_busy),
    .beam_valid(beam_valid), .beam_state(beam_state), .beam_end(beam_end), .scan_start(scan_start),
    .out_valid(out_valid), .out_state(out_state), .out_last(out_last));
  scbb_partner i_scbb_partner (.clk(clk), .rst_b(rst_b), .scan_start(scan_start), .pattern(pattern),
    .beam_valid(beam_valid), .beam_state(beam_state), .beam_end(beam_end), .fire(fire), .trig_drv(trig_drv));

  task tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task check(input string what, input logic [207:0] seen, input logic [207:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function logic sig(input int k);
    case (k)
      0: sig = out_last;
      1: sig = out_valid;
      2: sig = teach_busy;
      default: sig = trig_line;
    endcase
  endfunction

  task automatic wait_lvl(input int k, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while (sig(k) !== lvl) begin
      @(negedge clk);
      cnt++;
      if (cnt > bound) begin
        n_mismatch++;
        $display("mismatch wait %0d expected %b seen timeout", k, lvl);
        tally_and_finish();
      end
    end
  endtask

  task automatic access(input logic wr, input logic [7:0] idx, input logic [207:0] wd);
    @(negedge clk);
    rec_wr = wr;
    rec_rd = !wr;
    rec_index = idx;
    rec_wdata = wd;
    @(negedge clk);
    rec_wr = 1'b0;
    rec_rd = 1'b0;
    check("rec_ack", rec_ack, 1'b1);
  endtask

  // Skips the pass in flight and captures the next whole pass
  task automatic grab(output logic [15:0] g);
    int k, c;
    wait_lvl(0, 1'b1, 400, c);
    @(negedge clk);
    for (k = 0; k < 16; k++) begin
      wait_lvl(1, 1'b1, 400, c);
      g[k] = out_state;
      @(negedge clk);
    end
  endtask

  task automatic teach(input logic panel);
    int c;
    @(negedge clk);
    teach_panel = panel;
    teach_cmd = !panel;
    @(negedge clk);
    teach_panel = 1'b0;
    teach_cmd = 1'b0;
    wait_lvl(2, 1'b1, 400, c);
    wait_lvl(2, 1'b0, 400, c);
  endtask

  initial begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    access(1'b0, 8'h49, '0);
    check("trig reset", rec_rdata, {144'h0, 64'h0000_01f4_0064_0001});
    access(1'b0, 8'h4c, '0);
    check("blank reset", rec_rdata, {16'h0000, {4{48'h0000_0001_0001}}});
    access(1'b1, 8'h4a, '1);
    access(1'b0, 8'h4a, '0);
    check("unmapped", rec_rdata, '0);
    grab(v);
    check("raw pass", v, PAT);
    access(1'b1, 8'h4c, BLK);
    access(1'b0, 8'h4c, '0);
    check("blank rw", rec_rdata, BLK);
    e = PAT;
    e[2:1] = 2'b00;
    e[5:4] = 2'b11;
    e[8:7] = {2{PAT[6]}};
    e[11:10] = {2{PAT[12]}};
    grab(v);
    check("substituted", v, e);
    pattern = 16'hcf3f;
    access(1'b1, 8'h4c, {8'h01, 8'h01, {4{48'h0001_0001_0001}}});
    teach(1'b0);
    access(1'b0, 8'h4c, '0);
    check("auto area", rec_rdata[191:144], 48'h0002_0007_0008);
    check("auto limit", rec_rdata[143:128], 16'h0000);
    access(1'b1, 8'h4c, TAUGHT);
    teach(1'b1);
    access(1'b0, 8'h4c, '0);
    check("manual kept", rec_rdata, TAUGHT);
    grab(v);
    check("taught pass", v, 16'hcfff);
    // Follower with its own delay, offset from the neighbour
    access(1'b1, 8'h49, {144'h0, 64'h0100_01f4_0064_0001});
    check("follower oe", trig_oe, 1'b0);
    repeat (200) @(negedge clk);
    s = 1'b0;
    repeat (200) begin
      @(negedge clk);
      s = s | scan_start;
    end
    check("no free scan", s, 1'b0);
    fire = 1'b1;
    for (n = 1; n <= 21000 && scan_start !== 1'b1; n++) begin
      @(negedge clk);
      fire = (n == 10000);
    end
    check("trigger delay", n >= 20000 && n <= 20050, 1'b1);
    if (n > 21000) tally_and_finish();
    access(1'b1, 8'h49, {144'h0, 64'h0101_01f4_0064_0001});
    // Output enable follows the new role one cycle after the write
    @(negedge clk);
    check("leader oe", trig_oe, 1'b1);
    wait_lvl(3, 1'b1, 41000, n);
    wait_lvl(3, 1'b0, 5000, n);
    check("pulse width", n >= 3999 && n <= 4041, 1'b1);
    wait_lvl(3, 1'b1, 41000, m);
    check("cycle period", n + m >= 39960 && n + m <= 40040, 1'b1);
    tally_and_finish();
  end
endmodule // scbb_top_tb
